// File: src/gpib_instrument_port.sv
`timescale 1ns/10ps
`include "gpib_port_defines.svh"

// What this block does
// - Controller's own addresses count as another device's.
// - Data is sourced only while addressed to talk.
// - Data is accepted only while addressed to listen.
// - Outgoing bytes use the source handshake.
// - Incoming bytes use the acceptor handshake.
// - Service request line can be asserted; status byte answers a serial poll.
// - Remote and local state follows remote enable, go-to-local and local lockout.
// - Universal clear, or selected clear while listening, clears the device.
// - Trigger command starts a reading while listening, or as the first command byte of an attention period.
// - No parallel poll; data lines are never driven for an identify.
// - Attention, interface clear and remote enable are inputs only.
// - Only primary addresses are decoded; secondary address bytes are ignored.
// - Any listen address unaddresses the talker; any talk address the listener.
// - Interface clear idles talker and listener and abandons a byte in flight; a service request stays.
module gpib_instrument_port (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Bus lines, electrical level (low means true).
    input wire logic [7:0] DIO_I,
    output logic [7:0] DIO_O,
    output logic [7:0] DIO_OE_O,
    input wire logic DAV_I,
    output logic DAV_O,
    output logic DAV_OE_O,
    input wire logic NRFD_I,
    output logic NRFD_O,
    output logic NRFD_OE_O,
    input wire logic NDAC_I,
    output logic NDAC_O,
    output logic NDAC_OE_O,
    input wire logic EOI_I,
    output logic EOI_O,
    output logic EOI_OE_O,
    input wire logic SRQ_I,
    output logic SRQ_O,
    output logic SRQ_OE_O,
    input wire logic ATN_I,
    input wire logic IFC_I,
    input wire logic REN_I,
    // Instrument side.
    input wire logic [4:0] ADDR_I,
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    input wire logic TX_END_I,
    output logic TX_TAKEN_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O,
    output logic RX_END_O,
    input wire logic [7:0] STATUS_I,
    input wire logic SRQ_REQ_I,
    output logic TALK_O,
    output logic LISTEN_O,
    output logic SPOLL_O,
    output logic REMOTE_O,
    output logic LOCKOUT_O,
    output logic TRIGGER_O,
    output logic DEV_CLEAR_O,
    output logic IFC_CLEAR_O
);
    import gpib_port_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Bus messages in true logic
    // ------------------------------------------------------------------------
    // Attention, clear and remote enable are only ever sampled here.
    logic atn;
    logic ifc;
    logic ren;
    logic dav_in;
    assign atn = !ATN_I;
    assign ifc = !IFC_I;
    assign ren = !REN_I;
    assign dav_in = !DAV_I;

    // Open-drain lines: the level is always low, only the enable moves.
    logic line_low_q;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            line_low_q <= 1'b0;
        end else begin
            line_low_q <= 1'b0;
        end
    end
    assign DIO_O = {8{line_low_q}};
    assign DAV_O = line_low_q;
    assign NRFD_O = line_low_q;
    assign NDAC_O = line_low_q;
    assign EOI_O = line_low_q;
    assign SRQ_O = line_low_q;

    // ------------------------------------------------------------------------
    // Acceptor handshake
    // ------------------------------------------------------------------------
    acc_state_t acc_q;
    logic nrfd_drv_q;
    logic ndac_drv_q;
    logic [7:0] cap_q;
    logic cap_atn_q;
    logic cap_eoi_q;
    logic listen_q;
    logic acc_active;

    // Every device must take part in command bytes, listeners in data bytes.
    assign acc_active = atn || listen_q;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= A_IDLE;
            nrfd_drv_q <= 1'b0;
            ndac_drv_q <= 1'b0;
            cap_q <= `BYTE_RESET;
            cap_atn_q <= 1'b0;
            cap_eoi_q <= 1'b0;
        end else begin
            case (acc_q)
                A_IDLE: begin
                    nrfd_drv_q <= 1'b0;
                    ndac_drv_q <= 1'b0;
                    if (acc_active) begin
                        ndac_drv_q <= 1'b1;
                        acc_q <= A_READY;
                    end
                end
                A_READY: begin
                    if (!acc_active) begin
                        ndac_drv_q <= 1'b0;
                        acc_q <= A_IDLE;
                    end else if (dav_in) begin
                        cap_q <= ~DIO_I;
                        cap_atn_q <= atn;
                        cap_eoi_q <= !EOI_I;
                        nrfd_drv_q <= 1'b1;
                        acc_q <= A_ACCEPT;
                    end
                end
                A_ACCEPT: begin
                    ndac_drv_q <= 1'b0;
                    acc_q <= A_WAIT;
                end
                default: begin
                    // Hold not-ready until the source drops data valid, so a
                    // byte can never be taken twice.
                    if (!dav_in) begin
                        nrfd_drv_q <= 1'b0;
                        ndac_drv_q <= 1'b1;
                        acc_q <= A_READY;
                    end
                end
            endcase
        end
    end
    assign NRFD_OE_O = nrfd_drv_q;
    assign NDAC_OE_O = ndac_drv_q;

    // ------------------------------------------------------------------------
    // Byte decode
    // ------------------------------------------------------------------------
    logic cmd_stb;
    logic dat_stb;
    logic [6:0] msg;
    logic [1:0] grp;
    logic own_addr;
    logic is_lag;
    logic is_tag;
    logic my_lag;
    logic my_tag;
    logic first_cmd_q;

    assign cmd_stb = (acc_q == A_ACCEPT) && cap_atn_q;
    assign dat_stb = (acc_q == A_ACCEPT) && !cap_atn_q && listen_q;
    assign msg = cap_q[6:0];
    assign grp = msg[`GRP_MSB:`GRP_LSB];
    // Secondary group bytes match neither group and so change nothing.
    assign is_lag = cmd_stb && (grp == `GRP_LISTEN) && (msg != `CMD_UNL);
    assign is_tag = cmd_stb && (grp == `GRP_TALK) && (msg != `CMD_UNT);
    // Other addresses, the controller's too, only unaddress.
    assign own_addr = (msg[`ADDR_MSB:`ADDR_LSB] == ADDR_I);
    assign my_lag = is_lag && own_addr;
    assign my_tag = is_tag && own_addr;

    // Set until the first command byte of an attention period.
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            first_cmd_q <= 1'b1;
        end else if (!atn) begin
            first_cmd_q <= 1'b1;
        end else if (cmd_stb) begin
            first_cmd_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Talker and listener addressing
    // ------------------------------------------------------------------------
    logic talk_q;
    logic spoll_q;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            listen_q <= 1'b0;
        end else if (ifc) begin
            listen_q <= 1'b0;
        end else if (my_lag) begin
            listen_q <= 1'b1;
        end else if ((cmd_stb && msg == `CMD_UNL) || is_tag) begin
            listen_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            talk_q <= 1'b0;
        end else if (ifc) begin
            talk_q <= 1'b0;
        end else if (my_tag) begin
            talk_q <= 1'b1;
        end else if ((cmd_stb && msg == `CMD_UNT) || is_lag) begin
            talk_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            spoll_q <= 1'b0;
        end else if (ifc) begin
            spoll_q <= 1'b0;
        end else if (cmd_stb && msg == `CMD_SPE) begin
            spoll_q <= 1'b1;
        end else if (cmd_stb && msg == `CMD_SPD) begin
            spoll_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Remote and local
    // ------------------------------------------------------------------------
    logic remote_q;
    logic lockout_q;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            remote_q <= 1'b0;
        end else if (!ren) begin
            remote_q <= 1'b0;
        end else if (my_lag) begin
            remote_q <= 1'b1;
        end else if (cmd_stb && msg == `CMD_GTL && listen_q) begin
            remote_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            lockout_q <= 1'b0;
        end else if (!ren) begin
            lockout_q <= 1'b0;
        end else if (cmd_stb && msg == `CMD_LLO) begin
            lockout_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Clear, trigger and received data
    // ------------------------------------------------------------------------
    logic ifc_q;
    logic trigger_q;
    logic dev_clear_q;
    logic ifc_clear_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic rx_end_q;

    // Parallel poll commands fall through with no effect.
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ifc_q <= 1'b0;
            trigger_q <= 1'b0;
            dev_clear_q <= 1'b0;
            ifc_clear_q <= 1'b0;
        end else begin
            ifc_q <= ifc;
            ifc_clear_q <= ifc && !ifc_q;
            trigger_q <= cmd_stb && (msg == `CMD_GET)
                && (listen_q || first_cmd_q);
            dev_clear_q <= cmd_stb && ((msg == `CMD_DCL)
                || (msg == `CMD_SDC && listen_q));
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_q <= `BYTE_RESET;
            rx_valid_q <= 1'b0;
            rx_end_q <= 1'b0;
        end else begin
            rx_valid_q <= dat_stb;
            if (dat_stb) begin
                rx_data_q <= cap_q;
                rx_end_q <= cap_eoi_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Service request
    // ------------------------------------------------------------------------
    logic srq_req_q;
    logic rqs_q;
    logic src_done;

    // A new request in the cycle the poll ends wins.
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            srq_req_q <= 1'b0;
            rqs_q <= 1'b0;
        end else begin
            srq_req_q <= SRQ_REQ_I;
            if (SRQ_REQ_I && !srq_req_q) begin
                rqs_q <= 1'b1;
            end else if (src_done && spoll_q) begin
                rqs_q <= 1'b0;
            end
        end
    end
    assign SRQ_OE_O = rqs_q;

    // ------------------------------------------------------------------------
    // Talker data path
    // ------------------------------------------------------------------------
    logic src_enable;
    logic src_valid;
    logic [7:0] src_byte;
    logic tx_taken_q;

    // Attention cuts the source off, so nothing is ever driven onto the data
    // lines for an identify.
    assign src_enable = talk_q && !atn && !ifc;
    assign src_valid = spoll_q ? 1'b1 : TX_VALID_I;
    assign src_byte = spoll_q ? {STATUS_I[7], rqs_q, STATUS_I[5:0]} : TX_DATA_I;

    gpib_source_handshake u_source (
        .clk_i(CLK_I),
        .rst_ni(rst_n),
        .enable_i(src_enable),
        .valid_i(src_valid),
        .end_i(TX_END_I && !spoll_q),
        .data_i(src_byte),
        .rfd_i(NRFD_I),
        .dac_i(NDAC_I),
        .dav_o(DAV_OE_O),
        .eoi_o(EOI_OE_O),
        .dio_o(DIO_OE_O),
        .done_o(src_done)
    );

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tx_taken_q <= 1'b0;
        end else begin
            tx_taken_q <= src_done && !spoll_q;
        end
    end

    // ------------------------------------------------------------------------
    // Instrument-side outputs
    // ------------------------------------------------------------------------
    assign TX_TAKEN_O = tx_taken_q;
    assign RX_DATA_O = rx_data_q;
    assign RX_VALID_O = rx_valid_q;
    assign RX_END_O = rx_end_q;
    assign TALK_O = talk_q;
    assign LISTEN_O = listen_q;
    assign SPOLL_O = spoll_q;
    assign REMOTE_O = remote_q;
    assign LOCKOUT_O = lockout_q;
    assign TRIGGER_O = trigger_q;
    assign DEV_CLEAR_O = dev_clear_q;
    assign IFC_CLEAR_O = ifc_clear_q;

endmodule

// File: common/gpib_port_defines.svh
`ifndef GPIB_PORT_DEFINES_SVH
`define GPIB_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define SETTLE_NS 2000
// A least time, so it rounds up to whole cycles.
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 8

// ----------------------------------------------------------------------------
// Multiline interface messages, seven bits, true logic
// ----------------------------------------------------------------------------
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_PPC 7'h05
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_PPU 7'h15
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f

// ----------------------------------------------------------------------------
// Address byte layout
// ----------------------------------------------------------------------------
`define GRP_MSB 6
`define GRP_LSB 5
`define ADDR_MSB 4
`define ADDR_LSB 0
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define GRP_SECONDARY 2'h3

// ----------------------------------------------------------------------------
// Status byte and reset values
// ----------------------------------------------------------------------------
`define STB_RQS_BIT 6
`define BYTE_RESET 8'h00

`endif

// File: common/gpib_port_pkg.sv
package gpib_port_pkg;

    // Acceptor handshake states, Gray coded except the step from wait back to ready.
    typedef enum logic [1:0] {
        A_IDLE   = 2'h0,
        A_READY  = 2'h1,
        A_ACCEPT = 2'h3,
        A_WAIT   = 2'h2
    } acc_state_t;

    // Source handshake states, Gray coded along the byte cycle.
    typedef enum logic [1:0] {
        S_IDLE    = 2'h0,
        S_SETTLE  = 2'h1,
        S_VALID   = 2'h3,
        S_RELEASE = 2'h2
    } src_state_t;

endpackage

// File: src/gpib_source_handshake.sv
`timescale 1ns/10ps
`include "gpib_port_defines.svh"

module gpib_source_handshake (
    input wire logic clk_i,
    input wire logic rst_ni,
    input wire logic enable_i,
    input wire logic valid_i,
    input wire logic end_i,
    input wire logic [7:0] data_i,
    input wire logic rfd_i,
    input wire logic dac_i,
    output logic dav_o,
    output logic eoi_o,
    output logic [7:0] dio_o,
    output logic done_o
);
    import gpib_port_pkg::*;

    src_state_t state_q;
    logic [`SETTLE_CNT_W-1:0] cnt_q;

    // ------------------------------------------------------------------------
    // Byte cycle
    // ------------------------------------------------------------------------
    // Dropping the enable (attention asserted or talker unaddressed) lets the
    // lines go at once; a byte in flight is abandoned.
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            state_q <= S_IDLE;
            cnt_q <= '0;
            dav_o <= 1'b0;
            eoi_o <= 1'b0;
            dio_o <= `BYTE_RESET;
            done_o <= 1'b0;
        end else if (!enable_i) begin
            state_q <= S_IDLE;
            dav_o <= 1'b0;
            eoi_o <= 1'b0;
            dio_o <= `BYTE_RESET;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (valid_i) begin
                        dio_o <= data_i;
                        eoi_o <= end_i;
                        cnt_q <= '0;
                        state_q <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (cnt_q != `SETTLE_CNT_W'(`SETTLE_CYCLES - 1)) begin
                        cnt_q <= cnt_q + `SETTLE_CNT_W'(1);
                    end else if (rfd_i && !dac_i) begin
                        // Data has settled and every acceptor is ready.
                        dav_o <= 1'b1;
                        state_q <= S_VALID;
                    end
                end
                S_VALID: begin
                    if (dac_i) begin
                        dav_o <= 1'b0;
                        done_o <= 1'b1;
                        state_q <= S_RELEASE;
                    end
                end
                default: begin
                    dio_o <= `BYTE_RESET;
                    eoi_o <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// File: sim/gpib_instrument_port_properties.sv
`timescale 1ns/10ps
module gpib_port_checker (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] DIO_OE_O,
    input wire logic DAV_I,
    input wire logic NRFD_I,
    input wire logic NDAC_I,
    input wire logic DAV_OE_O,
    input wire logic NRFD_OE_O,
    input wire logic NDAC_OE_O,
    input wire logic SRQ_OE_O,
    input wire logic ATN_I,
    input wire logic IFC_I,
    input wire logic REN_I,
    input wire logic TX_TAKEN_O,
    input wire logic RX_VALID_O,
    input wire logic TALK_O,
    input wire logic LISTEN_O,
    input wire logic SPOLL_O,
    input wire logic REMOTE_O,
    input wire logic LOCKOUT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_take;
        !DAV_I && !NRFD_OE_O && NDAC_OE_O && (!ATN_I || LISTEN_O) && IFC_I;
    endsequence
    sequence s_settle;
        !DAV_OE_O [*8];
    endsequence
    property p_accept;
        s_take |-> ##[1:3] (NRFD_OE_O && !NDAC_OE_O);
    endproperty
    a_accept: assert property (p_accept) else $error("byte not accepted");
    property p_hold;
        NRFD_OE_O && !DAV_I && IFC_I && (!ATN_I || LISTEN_O) |=> NRFD_OE_O;
    endproperty
    a_hold: assert property (p_hold) else $error("ready while data valid");
    property p_src_ready;
        $rose(DAV_OE_O) |-> $past(NRFD_I) && !$past(NDAC_I);
    endproperty
    a_src_ready: assert property (p_src_ready) else $error("data valid too early");
    property p_settle;
        $rose(|DIO_OE_O) |=> s_settle;
    endproperty
    a_settle: assert property (p_settle) else $error("no settle time");
    property p_src_done;
        DAV_OE_O && NDAC_I && ATN_I && TALK_O |=> !DAV_OE_O ##[0:1] (TX_TAKEN_O || SPOLL_O);
    endproperty
    a_src_done: assert property (p_src_done) else $error("source did not finish");
    property p_talk_only;
        $rose(|DIO_OE_O) |-> $past(TALK_O) && $past(ATN_I);
    endproperty
    a_talk_only: assert property (p_talk_only) else $error("data driven untalked");
    property p_atn_quiet;
        !ATN_I |=> DIO_OE_O == 8'h00 && !DAV_OE_O;
    endproperty
    a_atn_quiet: assert property (p_atn_quiet) else $error("drove bus under attention");
    property p_rqs;
        SPOLL_O && DAV_OE_O |-> DIO_OE_O[6] == SRQ_OE_O;
    endproperty
    a_rqs: assert property (p_rqs) else $error("status bit 6 wrong");
    property p_local;
        REN_I |=> !REMOTE_O && !LOCKOUT_O;
    endproperty
    a_local: assert property (p_local) else $error("remote without enable");
    property p_ifc;
        !IFC_I |=> !TALK_O && !LISTEN_O && !SPOLL_O;
    endproperty
    a_ifc: assert property (p_ifc) else $error("not idle after clear");
    property p_rx;
        RX_VALID_O |-> LISTEN_O && ATN_I;
    endproperty
    a_rx: assert property (p_rx) else $error("data taken unlistened");
endmodule

bind gpib_instrument_port gpib_port_checker u_chk (.CLK_I, .RST_B_I, .DIO_OE_O, .DAV_I,
    .NRFD_I, .NDAC_I, .DAV_OE_O, .NRFD_OE_O, .NDAC_OE_O, .SRQ_OE_O, .ATN_I, .IFC_I, .REN_I,
    .TX_TAKEN_O, .RX_VALID_O, .TALK_O, .LISTEN_O, .SPOLL_O, .REMOTE_O, .LOCKOUT_O);

// File: sim/gpib_ctrl_model.sv
`timescale 1ns/10ps
module gpib_ctrl_model (
    input wire logic clk_i,
    input wire logic [7:0] dio_i,
    input wire logic dav_i,
    input wire logic nrfd_i,
    input wire logic ndac_i,
    input wire logic eoi_i,
    output logic [7:0] dio_o,
    output logic dav_o,
    output logic nrfd_o,
    output logic ndac_o,
    output logic eoi_o,
    output logic atn_o
);
    // A one on an output pulls its line low.
    int gap = 4;
    initial {dio_o, dav_o, nrfd_o, ndac_o, eoi_o, atn_o} = '0;
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
        int n;
        step(1);
        {atn_o, nrfd_o, ndac_o} = {atn, 2'b00};
        for (n = 0; n < 1000 && !(nrfd_i && !ndac_i); n++) step(1);
        {dio_o, eoi_o} = {b, eoi};
        step(gap);
        dav_o = 1'b1;
        for (n = 0; n < 1000 && !ndac_i; n++) step(1);
        {dav_o, dio_o, eoi_o} = '0;
        step(2);
    endtask
    task automatic idle();
        step(1);
        atn_o = 1'b0;
        step(3);
    endtask
    // Holding not-ready after the byte keeps a repeating talker parked.
    task automatic recv(output logic [7:0] b, output logic e);
        int n;
        step(1);
        {atn_o, nrfd_o, ndac_o} = 3'b001;
        for (n = 0; n < 1000 && dav_i; n++) step(1);
        {b, e} = {~dio_i, ~eoi_i};
        step(gap);
        {nrfd_o, ndac_o} = 2'b10;
        for (n = 0; n < 1000 && !dav_i; n++) step(1);
        ndac_o = 1'b1;
    endtask
endmodule

// File: sim/gpib_instrument_port_tb_top.sv
`timescale 1ns/10ps
module gpib_instrument_port_tb_top;
    localparam logic [4:0] DEV = 5'h10;
    logic [4:0] addr = DEV;
    logic clk = 1'b0, rst_b = 1'b0, ifc_pl = 1'b0, ren_pl = 1'b0;
    logic tx_valid = 1'b0, tx_end = 1'b0, srq_req = 1'b0, rx_e;
    logic [7:0] tx_data = 8'h00, status = 8'h05, rx_last, b;
    logic [7:0] rx_n = 8'h00, trig_n = 8'h00, clr_n = 8'h00, ifc_n = 8'h00;
    logic e;
    int mismatches = 0, cmp_count = 0;
    wire [7:0] dio_oe, dio_pl, rx_data;
    wire dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, dav_pl, nrfd_pl, ndac_pl, eoi_pl, atn_pl;
    wire tx_taken, rx_valid, rx_end, talk, listen, spoll, remote, lockout, trig, dclr, ifcc;
    wire [7:0] dio_l = ~(dio_oe | dio_pl);
    wire dav_l = ~(dav_oe | dav_pl);
    wire nrfd_l = ~(nrfd_oe | nrfd_pl);
    wire ndac_l = ~(ndac_oe | ndac_pl);
    wire eoi_l = ~(eoi_oe | eoi_pl);
    wire [7:0] state = {2'b00, srq_oe, talk, listen, spoll, remote, lockout};

    always #10 clk = ~clk;

    gpib_instrument_port u_dut (.CLK_I(clk), .RST_B_I(rst_b), .DIO_I(dio_l), .DIO_O(),
        .DIO_OE_O(dio_oe), .DAV_I(dav_l), .DAV_O(), .DAV_OE_O(dav_oe), .NRFD_I(nrfd_l),
        .NRFD_O(), .NRFD_OE_O(nrfd_oe), .NDAC_I(ndac_l), .NDAC_O(),
        .NDAC_OE_O(ndac_oe), .EOI_I(eoi_l), .EOI_O(), .EOI_OE_O(eoi_oe),
        .SRQ_I(~srq_oe), .SRQ_O(), .SRQ_OE_O(srq_oe), .ATN_I(~atn_pl),
        .IFC_I(~ifc_pl), .REN_I(~ren_pl), .ADDR_I(addr), .TX_DATA_I(tx_data),
        .TX_VALID_I(tx_valid), .TX_END_I(tx_end), .TX_TAKEN_O(tx_taken), .RX_DATA_O(rx_data),
        .RX_VALID_O(rx_valid), .RX_END_O(rx_end), .STATUS_I(status), .SRQ_REQ_I(srq_req),
        .TALK_O(talk), .LISTEN_O(listen), .SPOLL_O(spoll), .REMOTE_O(remote),
        .LOCKOUT_O(lockout), .TRIGGER_O(trig), .DEV_CLEAR_O(dclr), .IFC_CLEAR_O(ifcc));

    gpib_ctrl_model u_ctrl (.clk_i(clk), .dio_i(dio_l), .dav_i(dav_l), .nrfd_i(nrfd_l),
        .ndac_i(ndac_l), .eoi_i(eoi_l), .dio_o(dio_pl), .dav_o(dav_pl), .nrfd_o(nrfd_pl),
        .ndac_o(ndac_pl), .eoi_o(eoi_pl), .atn_o(atn_pl));

    always @(posedge clk) begin
        if (rx_valid === 1'b1) {rx_n, rx_last, rx_e} <= {rx_n + 8'h01, rx_data, rx_end};
        trig_n <= trig_n + {7'h00, trig === 1'b1};
        clr_n <= clr_n + {7'h00, dclr === 1'b1};
        ifc_n <= ifc_n + {7'h00, ifcc === 1'b1};
    end
    // The source takes a new byte one edge after the taken pulse appears.
    always @(posedge clk) #1 if (tx_taken === 1'b1) tx_valid = 1'b0;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        u_ctrl.send(c, 1'b1, 1'b0);
    endtask

    task automatic t_write();
        ren_pl = 1'b1;
        cmd(8'h55);
        cmd(8'h3f);
        cmd(8'h35);
        chk("state", 8'h00, state);
        cmd(8'h30);
        chk("state", 8'h0a, state);
        u_ctrl.send(8'ha5, 1'b0, 1'b0);
        u_ctrl.send(8'h3c, 1'b0, 1'b1);
        chk("rx count", 8'h02, rx_n);
        chk("rx data", 8'h3c, rx_last);
        chk("rx end", 8'h01, {7'h00, rx_e});
        cmd(8'h3f);
        u_ctrl.send(8'h77, 1'b0, 1'b0);
        chk("rx count", 8'h02, rx_n);
        cmd(8'h30);
        cmd(8'h70);
        chk("state", 8'h0a, state);
        $display("t_write done");
    endtask

    task automatic t_cmds();
        cmd(8'h08);
        cmd(8'h04);
        cmd(8'h11);
        cmd(8'h01);
        chk("state", 8'h09, state);
        cmd(8'h3f);
        cmd(8'h04);
        cmd(8'h08);
        u_ctrl.send(8'h05, 1'b1, 1'b1);
        chk("state", 8'h01, state);
        chk("triggers", 8'h01, trig_n);
        chk("clears", 8'h01, clr_n);
        u_ctrl.idle();
        cmd(8'h08);
        cmd(8'h14);
        chk("triggers", 8'h02, trig_n);
        chk("clears", 8'h02, clr_n);
        $display("t_cmds done");
    endtask

    task automatic t_read();
        u_ctrl.gap = 30;
        {tx_data, tx_end, tx_valid} = {8'h5a, 2'b01};
        cmd(8'h3f);
        cmd(8'h35);
        cmd(8'h50);
        chk("state", 8'h11, state);
        u_ctrl.recv(b, e);
        chk("tx byte", 8'h5a, b);
        for (int n = 0; n < 200 && tx_valid; n++) @(posedge clk);
        u_ctrl.step(1);
        {tx_data, tx_end, tx_valid} = {8'hc3, 2'b11};
        u_ctrl.recv(b, e);
        chk("tx byte", 8'hc3, b);
        chk("tx end", 8'h01, {7'h00, e});
        u_ctrl.step(3);
        cmd(8'h2a);
        chk("state", 8'h01, state);
        u_ctrl.gap = 4;
        $display("t_read done");
    endtask

    task automatic t_spoll();
        {srq_req, status} = {1'b1, 8'h85};
        u_ctrl.step(4);
        chk("state", 8'h21, state);
        cmd(8'h3f);
        cmd(8'h35);
        cmd(8'h50);
        cmd(8'h18);
        chk("state", 8'h35, state);
        u_ctrl.recv(b, e);
        chk("status", 8'hc5, b);
        u_ctrl.step(3);
        chk("state", 8'h15, state);
        cmd(8'h19);
        cmd(8'h5f);
        chk("state", 8'h01, state);
        srq_req = 1'b0;
        $display("t_spoll done");
    endtask

    task automatic t_ifc();
        cmd(8'h30);
        cmd(8'h50);
        chk("state", 8'h13, state);
        u_ctrl.idle();
        ifc_pl = 1'b1;
        u_ctrl.step(3);
        ifc_pl = 1'b0;
        u_ctrl.step(3);
        chk("state", 8'h03, state);
        chk("ifc pulses", 8'h01, ifc_n);
        ren_pl = 1'b0;
        u_ctrl.step(3);
        chk("state", 8'h00, state);
        addr = 5'h0a;
        cmd(8'h30);
        cmd(8'h2a);
        chk("state", 8'h08, state);
        $display("t_ifc done");
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        u_ctrl.step(4);
        t_write();
        t_cmds();
        t_read();
        t_spoll();
        t_ifc();
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
